//--- verilog/wdr_cfg.svh
`ifndef WDR_CFG_SVH
`define WDR_CFG_SVH

// System clock period in ns (100 MHz)
`define WDR_CLK_NS 10
// Start-up delay after the last reset source goes away, in us
`define WDR_STARTUP_US 65
// Watchdog oscillator nominal frequency, in Hz
`define WDR_OSC_HZ 1000000
// Shortest watchdog time-out in oscillator cycles (select code 000)
`define WDR_WDT_BASE_CYC 16384
// Change enable window length in system cycles
`define WDR_CE_CYCLES 3'h4

// Byte addresses on the register bus
`define WDR_ADR_CAUSE 8'h00
`define WDR_ADR_WDTCTL 8'h04

// Reset cause register fields
`define WDR_CAUSE_DBG 4
`define WDR_CAUSE_WDT 3
`define WDR_CAUSE_BO 2
`define WDR_CAUSE_EXT 1
`define WDR_CAUSE_POR 0
`define WDR_CAUSE_RST 5'h00
// Flags that stay in legacy compatibility mode
`define WDR_CAUSE_LEGACY_MASK 5'h03

// Watchdog control register fields
`define WDR_CTL_CE 4
`define WDR_CTL_EN 3
`define WDR_CTL_TS_HI 2
`define WDR_CTL_TS_LO 0
`define WDR_TS_RST 3'h0

`endif

//--- verilog/wdr_pkg.sv
package wdr_pkg;

  // Watchdog safety level derived from the fuses
  typedef enum logic [1:0] {
    WDR_LVL0,
    WDR_LVL1,
    WDR_LVL2
  } wdr_level_type;

endpackage : wdr_pkg

//--- verilog/wdr_top.sv
`include "wdr_cfg.svh"

module wdr_top #(
  // Start-up delay in system cycles; shorten for simulation
  parameter int P_STARTUP_CYC = `WDR_STARTUP_US * 1000 / `WDR_CLK_NS,
  // Watchdog base time-out in oscillator cycles
  parameter int P_WDT_BASE_CYC = `WDR_WDT_BASE_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  // Classic Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Reset sources
  input wire logic i_power_on_det,
  input wire logic i_ext_reset_n,
  input wire logic i_brownout_detector,
  input wire logic i_brownout_enable_fuse,
  input wire logic i_debug_reset_instruction,
  // Fuses
  input wire logic i_legacy_compat_fuse,
  input wire logic i_always_on_fuse,
  // Watchdog oscillator and restart instruction
  input wire logic i_wdt_osc,
  input wire logic i_wdt_restart,
  // Results
  output logic o_int_reset,
  output logic o_wdt_enabled,
  output logic [1:0] o_safety_level
);

  // Width of the start-up stretch counter
  localparam int STRETCH_W = 24;
  // Width of the watchdog counter, holds 2048K
  localparam int WDT_W = 22;
  // Start-up count at counter width
  localparam logic [STRETCH_W-1:0] STARTUP_LD =
    STRETCH_W'(P_STARTUP_CYC);
  // Base time-out at counter width
  localparam logic [WDT_W-1:0] WDT_BASE = WDT_W'(P_WDT_BASE_CYC);

  // Qualified reset sources, all active high
  logic src_por;
  logic src_ext;
  logic src_bo;
  logic src_dbg;
  // Any source, including the watchdog pulse
  logic src_any;
  // Start-up stretch counter
  logic [STRETCH_W-1:0] stretch_r;
  // Stretch still running
  logic stretch_busy;

  // Watchdog expiry pulse, one system cycle
  logic wdt_pulse_r;
  // Watchdog counter and its time-out limit
  logic [WDT_W-1:0] wdt_cnt_r;
  logic [WDT_W-1:0] wdt_limit;
  // Oscillator edge detection
  logic osc_d_r;
  logic osc_tick;

  // Control register state
  logic wde_r;
  logic change_enable_r;
  logic [2:0] wdp_r;
  logic [2:0] ce_cnt_r;
  // Fuse-derived level and initial enable
  wdr_pkg::wdr_level_type level;
  logic wde_init;

  // Reset cause flags
  logic [4:0] cause_r;
  logic [4:0] cause_nxt;
  logic [4:0] cause_impl;

  // Bus decode
  logic bus_req;
  logic bus_commit;
  logic wr_cause;
  logic wr_ctl;
  logic [7:0] wr_byte;
  logic [7:0] rd_mux;
  logic [7:0] ctl_view;

  // Source qualification; pin and detectors act without a clock
  // The brown-out detector only counts when its fuse is programmed
  always_comb begin
    src_por = i_power_on_det;
    src_ext = !i_ext_reset_n;
    src_bo = i_brownout_detector && i_brownout_enable_fuse;
    src_dbg = i_debug_reset_instruction;
    src_any = src_por || src_ext || src_bo || src_dbg || wdt_pulse_r;
  end

  // Stretch counter: reloaded while a source is active
  // A watchdog pulse reloads it too, so counting starts
  // on the falling edge of that one-cycle pulse
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stretch_r <= STARTUP_LD;
    end else if (src_any) begin
      // Held at full count; counting begins when sources drop
      stretch_r <= STARTUP_LD;
    end else if (stretch_r != '0) begin
      stretch_r <= stretch_r - STRETCH_W'(1);
    end
  end

  assign stretch_busy = (stretch_r != '0);

  // Internal reset: raw sources pass straight through
  // so a stopped clock cannot hold off the reset
  always_comb begin
    o_int_reset = src_any || stretch_busy;
  end

  // Safety level from the two fuses
  // Always-on wins over the legacy fuse when both are programmed
  always_comb begin
    if (i_always_on_fuse) begin
      level = wdr_pkg::WDR_LVL2;
    end else if (i_legacy_compat_fuse) begin
      level = wdr_pkg::WDR_LVL0;
    end else begin
      level = wdr_pkg::WDR_LVL1;
    end
    // Only level 2 starts enabled
    wde_init = (level == wdr_pkg::WDR_LVL2);
    o_safety_level = level;
  end

  // Implemented flags depend on the legacy fuse
  always_comb begin
    if (i_legacy_compat_fuse) begin
      cause_impl = `WDR_CAUSE_LEGACY_MASK;
    end else begin
      cause_impl = 5'h1F;
    end
  end

  // Bus handshake: answer one cycle after the request
  assign bus_req = i_wb_cyc && i_wb_stb;
  // Write lands on the edge the master sees ack
  assign bus_commit = bus_req && o_wb_ack && i_wb_we && i_wb_sel[0];
  assign wr_cause = bus_commit && (i_wb_adr == `WDR_ADR_CAUSE);
  assign wr_ctl = bus_commit && (i_wb_adr == `WDR_ADR_WDTCTL);
  assign wr_byte = i_wb_dat[7:0];

  // Acknowledge register, drops the cycle after it is given
  // Registered ack costs a cycle but keeps the bus path short;
  // the !o_wb_ack term stops a held request being answered twice
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
    end else begin
      o_wb_ack <= bus_req && !o_wb_ack;
    end
  end

  // Control register as seen by software
  always_comb begin
    ctl_view = 8'h00;
    ctl_view[`WDR_CTL_CE] = change_enable_r;
    // Level 2 always shows enabled
    ctl_view[`WDR_CTL_EN] = wde_r || (level == wdr_pkg::WDR_LVL2);
    ctl_view[`WDR_CTL_TS_HI:`WDR_CTL_TS_LO] = wdp_r;
  end

  // Read mux; unmapped addresses read as zero
  // Unimplemented flags are masked here as well as at the source
  always_comb begin
    unique case (i_wb_adr)
      `WDR_ADR_CAUSE: rd_mux = {3'h0, cause_r & cause_impl};
      `WDR_ADR_WDTCTL: rd_mux = ctl_view;
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data captured with the acknowledge
  // Loaded on the taking edge so it stands while ack is high
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_wb_dat <= 32'h0000_0000;
    end else if (bus_req && !o_wb_ack && !i_wb_we) begin
      o_wb_dat <= {24'h00_0000, rd_mux};
    end
  end

  // Flag next state; a set in the clear cycle wins
  always_comb begin
    cause_nxt = cause_r;
    // Software clears by writing zero, ones are ignored
    if (wr_cause) begin
      cause_nxt = cause_nxt & wr_byte[4:0];
    end
    // Power-on clears every flag except itself and debug
    if (src_por) begin
      cause_nxt[`WDR_CAUSE_WDT] = 1'b0;
      cause_nxt[`WDR_CAUSE_BO] = 1'b0;
      cause_nxt[`WDR_CAUSE_EXT] = 1'b0;
    end
    // Brown-out clears the debug flag
    if (src_bo) begin
      cause_nxt[`WDR_CAUSE_DBG] = 1'b0;
    end
    // Sets come last so they win over every clear but the brown-out clear of debug
    if (src_por) begin
      cause_nxt[`WDR_CAUSE_POR] = 1'b1;
    end
    if (src_ext) begin
      cause_nxt[`WDR_CAUSE_EXT] = 1'b1;
    end
    if (src_bo) begin
      cause_nxt[`WDR_CAUSE_BO] = 1'b1;
    end
    if (wdt_pulse_r) begin
      cause_nxt[`WDR_CAUSE_WDT] = 1'b1;
    end
    if (src_dbg && !src_bo) begin
      cause_nxt[`WDR_CAUSE_DBG] = 1'b1;
    end
    // Unimplemented flags never hold a one
    cause_nxt = cause_nxt & cause_impl;
  end

  // Reset cause register; not touched by the internal reset
  // Flags must survive the reset they record, so only i_rst clears
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cause_r <= `WDR_CAUSE_RST;
    end else begin
      cause_r <= cause_nxt;
    end
  end

  // Change window: open four cycles after a qualifying write
  // The internal reset closes it, so a stale window can never
  // survive a chip reset and unlock the next boot
  always_ff @(posedge i_clk) begin
    if (i_rst || o_int_reset) begin
      change_enable_r <= 1'b0;
      ce_cnt_r <= 3'h0;
    end else if (wr_ctl && wr_byte[`WDR_CTL_CE] && wr_byte[`WDR_CTL_EN]) begin
      // Both ones in one write open or restart the window
      change_enable_r <= 1'b1;
      ce_cnt_r <= `WDR_CE_CYCLES;
    end else if (wr_ctl) begin
      // Second step uses the window, then closes it
      change_enable_r <= 1'b0;
      ce_cnt_r <= 3'h0;
    end else if (ce_cnt_r == 3'h1) begin
      // Window lapses; configuration stays as it was
      change_enable_r <= 1'b0;
      ce_cnt_r <= 3'h0;
    end else if (ce_cnt_r != 3'h0) begin
      ce_cnt_r <= ce_cnt_r - 3'h1;
    end
  end

  // Watchdog enable bit
  // Priority: reset, level 2 lock, enable, then guarded disable;
  // enable ranks above disable so a write of one never loses
  always_ff @(posedge i_clk) begin
    if (i_rst || o_int_reset) begin
      wde_r <= wde_init;
    end else if (level == wdr_pkg::WDR_LVL2) begin
      // Stays on whatever is written
      wde_r <= 1'b1;
    end else if (wr_ctl && wr_byte[`WDR_CTL_EN]) begin
      // Enabling needs no unlock at any level
      wde_r <= 1'b1;
    end else if (wr_ctl && change_enable_r) begin
      // Zero accepted only with the window open
      wde_r <= 1'b0;
    end
  end

  // Time-out select field
  // At levels 1 and 2 writes outside the window are dropped silently, no error flag
  always_ff @(posedge i_clk) begin
    if (i_rst || o_int_reset) begin
      wdp_r <= `WDR_TS_RST;
    end else if (wr_ctl) begin
      // Level 0 changes freely, others need the window
      if (level == wdr_pkg::WDR_LVL0 || change_enable_r) begin
        wdp_r <= wr_byte[`WDR_CTL_TS_HI:`WDR_CTL_TS_LO];
      end
    end
  end

  assign o_wdt_enabled = wde_r;

  // Oscillator sampled as a plain input; rising edge is a tick
  // Limitation: the oscillator must run below half the bus clock,
  // or ticks are missed and the time-out stretches
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      osc_d_r <= 1'b0;
    end else begin
      osc_d_r <= i_wdt_osc;
    end
  end

  // One tick per oscillator period, detected on the bus clock
  assign osc_tick = i_wdt_osc && !osc_d_r;

  // Time-out limit doubles with each select code
  always_comb begin
    wdt_limit = WDT_BASE << wdp_r;
  end

  // Watchdog counter
  // Wraps at the limit; the expiry pulse and the reset it raises
  // then clear it, so no second pulse can follow in the same spell
  always_ff @(posedge i_clk) begin
    if (i_rst || o_int_reset || !wde_r || i_wdt_restart) begin
      // Cleared by reset, disable and the restart instruction
      wdt_cnt_r <= '0;
    end else if (osc_tick) begin
      if (wdt_cnt_r == wdt_limit - WDT_W'(1)) begin
        wdt_cnt_r <= '0;
      end else begin
        wdt_cnt_r <= wdt_cnt_r + WDT_W'(1);
      end
    end
  end

  // Expiry pulse; the chip reset that follows clears the counter
  // Gated by the internal reset so a running stretch cannot expire
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wdt_pulse_r <= 1'b0;
    end else begin
      wdt_pulse_r <= !o_int_reset && wde_r && !i_wdt_restart && osc_tick
        && (wdt_cnt_r == wdt_limit - WDT_W'(1));
    end
  end

endmodule : wdr_top

//--- bench/wdr_top_asserts.sv
module wdr_top_asserts #(
  parameter int P_STARTUP_CYC = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic o_wb_ack,
  input wire logic i_power_on_det,
  input wire logic i_ext_reset_n,
  input wire logic i_brownout_detector,
  input wire logic i_brownout_enable_fuse,
  input wire logic i_debug_reset_instruction,
  input wire logic i_legacy_compat_fuse,
  input wire logic i_always_on_fuse,
  input wire logic o_int_reset,
  input wire logic o_wdt_enabled,
  input wire logic [1:0] o_safety_level
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // Any pin or detector reset source active now, not the watchdog pulse
  logic src;
  // Quiet cycles since the last source
  int quiet_r;
  assign src = i_power_on_det | ~i_ext_reset_n | i_debug_reset_instruction
    | (i_brownout_enable_fuse & i_brownout_detector);
  // Saturates so the release point is seen once per quiet spell
  always_ff @(posedge i_clk) begin
    if (i_rst || src) begin
      quiet_r <= 0;
    end else if (quiet_r <= P_STARTUP_CYC) begin
      quiet_r <= quiet_r + 1;
    end
  end
  // Request not yet answered
  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  // Ack for one cycle, then low
  sequence s_ack;
    o_wb_ack ##1 !o_wb_ack;
  endsequence
  a_ack_next: assert property (s_req |=> s_ack)
    else $error("bus request not acked for exactly one cycle");
  a_por_now: assert property (i_power_on_det |-> o_int_reset)
    else $error("power-on source without internal reset");
  a_ext_now: assert property (!i_ext_reset_n |-> o_int_reset)
    else $error("reset pin low without internal reset");
  a_bo_now: assert property (
    i_brownout_enable_fuse && i_brownout_detector |-> o_int_reset)
    else $error("brown-out without internal reset");
  a_level_map: assert property (o_safety_level ==
    (i_always_on_fuse ? 2'h2 : i_legacy_compat_fuse ? 2'h0 : 2'h1))
    else $error("safety level does not follow the fuses");
  a_lvl2_on: assert property (
    o_safety_level == 2'h2 && $stable(o_safety_level) |=> o_wdt_enabled)
    else $error("watchdog off at safety level 2");
  a_stretch_hold: assert property (
    quiet_r < P_STARTUP_CYC |-> o_int_reset)
    else $error("internal reset released before the stretch");
  a_stretch_end: assert property (
    quiet_r == P_STARTUP_CYC |-> !o_int_reset)
    else $error("internal reset held past the stretch");
endmodule : wdr_top_asserts

bind wdr_top wdr_top_asserts #(.P_STARTUP_CYC(P_STARTUP_CYC)) u_chk (
  .i_clk, .i_rst, .i_wb_cyc, .i_wb_stb, .o_wb_ack, .i_power_on_det,
  .i_ext_reset_n, .i_brownout_detector, .i_brownout_enable_fuse,
  .i_debug_reset_instruction, .i_legacy_compat_fuse, .i_always_on_fuse,
  .o_int_reset, .o_wdt_enabled, .o_safety_level);

//--- bench/wdr_top_tb.sv
`include "wdr_cfg.svh"

module wdr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_C = `WDR_ADR_CAUSE;
  localparam logic [7:0] A_W = `WDR_ADR_WDTCTL;
  logic i_clk = 1'h0, i_rst = 1'h1;
  logic i_wb_cyc = 1'h0, i_wb_stb = 1'h0, i_wb_we = 1'h0;
  logic [7:0] i_wb_adr = 8'h00;
  logic [3:0] i_wb_sel = 4'h1;
  logic [31:0] i_wb_dat = 32'h0, o_wb_dat;
  logic o_wb_ack, o_int_reset, o_wdt_enabled;
  logic [1:0] o_safety_level;
  logic i_power_on_det = 1'h0, i_ext_reset_n = 1'h1;
  logic i_brownout_detector = 1'h0, i_brownout_enable_fuse = 1'h1;
  logic i_debug_reset_instruction = 1'h0, i_legacy_compat_fuse = 1'h0;
  logic i_always_on_fuse = 1'h0, i_wdt_osc = 1'h0, i_wdt_restart = 1'h0;
  // Oscillator gate and divider
  logic osc_run = 1'h0;
  logic [1:0] div_r = 2'h0;
  int n_fail = 0, n_checks = 0;

  // Short stretch and time-out keep the run brief
  wdr_top #(.P_STARTUP_CYC(8), .P_WDT_BASE_CYC(4)) uut (
    .i_clk, .i_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
    .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_power_on_det,
    .i_ext_reset_n, .i_brownout_detector, .i_brownout_enable_fuse,
    .i_debug_reset_instruction, .i_legacy_compat_fuse,
    .i_always_on_fuse, .i_wdt_osc, .i_wdt_restart, .o_int_reset,
    .o_wdt_enabled, .o_safety_level);

  initial begin
    forever #5 i_clk = ~i_clk;
  end

  // Quarter rate, well under half the system clock; still when gated
  always @(posedge i_clk) begin
    div_r <= div_r + 2'h1;
    i_wdt_osc <= osc_run & div_r[1];
  end

  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic timeout(string what);
    n_fail++;
    $display("mismatch %s expected done seen timeout", what);
    complete_run();
  endtask : timeout

  // One classic cycle; data taken at the ack edge only
  task automatic wb(logic we, logic [7:0] adr, logic [7:0] d,
                    output logic [7:0] q);
    int k;
    @(posedge i_clk);
    i_wb_cyc <= 1'h1;
    i_wb_stb <= 1'h1;
    i_wb_we <= we;
    i_wb_adr <= adr;
    i_wb_dat <= {24'h0, d};
    for (k = 0; k < 20; k++) begin
      @(posedge i_clk);
      if (o_wb_ack === 1'h1) break;
    end
    q = o_wb_dat[7:0];
    i_wb_cyc <= 1'h0;
    i_wb_stb <= 1'h0;
    if (k == 20) timeout("ack");
  endtask : wb

  task automatic wr(logic [7:0] adr, logic [7:0] d);
    logic [7:0] q;
    wb(1'h1, adr, d, q);
  endtask : wr

  task automatic rd(logic [7:0] adr, logic [7:0] exp);
    logic [7:0] q;
    wb(1'h0, adr, 8'h00, q);
    check($sformatf("reg %h", adr), exp, q);
  endtask : rd

  task automatic wait_low();
    int k;
    for (k = 0; k < 400 && o_int_reset !== 1'h0; k++) begin
      @(posedge i_clk);
      #1;
    end
    if (k == 400) timeout("reset release");
  endtask : wait_low

  // Holds one source for three cycles, then waits out the stretch
  task automatic pulse(int s);
    @(posedge i_clk);
    case (s)
      0: i_power_on_det <= 1'h1;
      1: i_ext_reset_n <= 1'h0;
      2: i_brownout_detector <= 1'h1;
      default: i_debug_reset_instruction <= 1'h1;
    endcase
    repeat (3) @(posedge i_clk);
    i_power_on_det <= 1'h0;
    i_ext_reset_n <= 1'h1;
    i_brownout_detector <= 1'h0;
    i_debug_reset_instruction <= 1'h0;
    wait_low();
  endtask : pulse

  // The two level fuses change only under reset, as at power-up
  task automatic do_rst(logic lg, logic on);
    @(posedge i_clk);
    i_rst <= 1'h1;
    i_legacy_compat_fuse <= lg;
    i_always_on_fuse <= on;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'h0;
    wait_low();
  endtask : do_rst

  task automatic t_flags();
    rd(A_C, 8'h00);
    pulse(0);
    rd(A_C, 8'h01);
    pulse(1);
    rd(A_C, 8'h03);
    pulse(2);
    rd(A_C, 8'h07);
    pulse(3);
    rd(A_C, 8'h17);
    pulse(2);
    rd(A_C, 8'h07);
    pulse(0);
    rd(A_C, 8'h01);
    wr(A_C, 8'h00);
    rd(A_C, 8'h00);
    i_brownout_enable_fuse <= 1'h0;
    pulse(2);
    rd(A_C, 8'h00);
    i_brownout_enable_fuse <= 1'h1;
    $display("flag test done");
  endtask : t_flags

  task automatic t_level1();
    rd(A_W, 8'h00);
    wr(A_W, 8'hE8);
    rd(A_W, 8'h08);
    check("enabled", 8'h01, {7'h00, o_wdt_enabled});
    wr(A_W, 8'h00);
    rd(A_W, 8'h08);
    wr(A_W, 8'h18);
    rd(A_W, 8'h18);
    wr(A_W, 8'h05);
    rd(A_W, 8'h08);
    wr(A_W, 8'h18);
    wr(A_W, 8'h0D);
    rd(A_W, 8'h0D);
    wr(A_W, 8'h18);
    wr(A_W, 8'h00);
    rd(A_W, 8'h00);
    check("enabled", 8'h00, {7'h00, o_wdt_enabled});
    wr(8'h08, 8'hFF);
    rd(8'h08, 8'h00);
    $display("level 1 test done");
  endtask : t_level1

  task automatic t_level0();
    do_rst(1'h1, 1'h0);
    check("level", 8'h00, {6'h00, o_safety_level});
    wr(A_W, 8'h03);
    rd(A_W, 8'h03);
    pulse(2);
    pulse(3);
    pulse(1);
    rd(A_C, 8'h02);
    $display("level 0 test done");
  endtask : t_level0

  task automatic t_level2();
    int n;
    do_rst(1'h0, 1'h1);
    check("level", 8'h02, {6'h00, o_safety_level});
    rd(A_W, 8'h08);
    wr(A_W, 8'h18);
    wr(A_W, 8'h00);
    rd(A_W, 8'h08);
    check("enabled", 8'h01, {7'h00, o_wdt_enabled});
    wr(A_W, 8'h18);
    wr(A_W, 8'h01);
    rd(A_W, 8'h09);
    @(posedge i_clk);
    osc_run <= 1'h1;
    i_wdt_restart <= 1'h1;
    n = 0;
    repeat (60) begin
      @(posedge i_clk);
      if (o_int_reset !== 1'h0) n++;
    end
    check("reset under restart", 8'h00, n[7:0]);
    i_wdt_restart <= 1'h0;
    for (n = 0; n < 60 && o_int_reset !== 1'h1; n++) @(posedge i_clk);
    // Eight ticks of four cycles plus sync slack
    check("expiry in range", 8'h01, {7'h0, n >= 28 && n <= 40});
    osc_run <= 1'h0;
    wait_low();
    rd(A_C, 8'h08);
    rd(A_W, 8'h08);
    pulse(0);
    rd(A_C, 8'h01);
    $display("level 2 test done");
  endtask : t_level2

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (6) @(posedge i_clk);
    i_rst <= 1'h0;
    wait_low();
    t_flags();
    t_level1();
    t_level0();
    t_level2();
    complete_run();
  end
endmodule : wdr_top_tb
